//--- logic/dbrc_map.vh
/*
 * Constants for the DDR4 bank and refresh command tracker: command
 * pin encodings, field positions and timing figures in nanoseconds.
 * Assumes a 100 MHz core clock and that every user includes it once.
 */
`ifndef DBRC_MAP_VH
`define DBRC_MAP_VH

// ****************************************
// Command decode (cs, act, ras, cas, we)
// ****************************************
`define DBRC_CMD_W 5
`define DBRC_CMD_PRE 5'h0a
`define DBRC_CMD_REF 5'h09
`define DBRC_CMD_WR 5'h0c
`define DBRC_CMD_RD 5'h0d
`define DBRC_CMD_MASK 5'h1f

// ****************************************
// Address fields
// ****************************************
`define DBRC_AP_BIT 10
`define DBRC_ROW_W 18
`define DBRC_BANKS 16

// ****************************************
// Timing figures, ns, and clock period
// ****************************************
`define DBRC_CLK_NS 10
`define DBRC_TRP_NS 14
`define DBRC_TRTP_NS 8
`define DBRC_TWR_NS 15
`define DBRC_TRFC1_NS 350
`define DBRC_TRFC2_NS 260
`define DBRC_TRFC4_NS 160

// ****************************************
// Refresh mode codes
// ****************************************
`define DBRC_RM_1X 2'h0
`define DBRC_RM_2X 2'h1
`define DBRC_RM_4X 2'h2

`endif

//--- logic/dbrc_bank.v
/*
 * One bank of the tracker: open row, precharge timer and the delayed
 * auto-precharge. Assumes commands arrive already decoded and
 * synchronous to clk_i.
 */
`default_nettype none
`include "dbrc_map.vh"

module dbrc_bank #(
	parameter ROW_W = `DBRC_ROW_W,
	parameter TW = 8,
	parameter [7:0] TRP_CYC = 8'h02,
	parameter [7:0] APR_CYC = 8'h01,
	parameter [7:0] APW_CYC = 8'h02
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Decoded commands for this bank
	input wire act_i,
	input wire pre_i,
	input wire rd_ap_i,
	input wire wr_ap_i,
	input wire ref_i,
	input wire [ROW_W-1:0] row_i,
	// Bank state
	output wire open_o,
	output wire [ROW_W-1:0] row_o,
	output wire idle_o
);

	reg open_ff;
	reg [ROW_W-1:0] row_ff;
	reg [TW-1:0] pre_cnt_ff;
	reg [TW-1:0] ap_cnt_ff;
	reg ap_pend_ff;

	assign idle_o = !open_ff && (pre_cnt_ff == {TW{1'b0}});
	assign open_o = open_ff;
	assign row_o = row_ff;

	// ****************************************
	// Row state and precharge timing
	// ****************************************
	// A late precharge restarts the timer from its own edge
	always @(posedge clk_i) begin
		if (rst_i || ref_i) begin
			open_ff <= 1'b0;
			row_ff <= {ROW_W{1'b0}};
			pre_cnt_ff <= {TW{1'b0}};
			ap_cnt_ff <= {TW{1'b0}};
			ap_pend_ff <= 1'b0;
		end else begin
			if (pre_cnt_ff != {TW{1'b0}})
				pre_cnt_ff <= pre_cnt_ff - 1'b1;
			if (act_i) begin
				open_ff <= 1'b1;
				row_ff <= row_i;
			end
			if (pre_i) begin
				open_ff <= 1'b0;
				ap_pend_ff <= 1'b0;
				pre_cnt_ff <= TRP_CYC[TW-1:0];
			end else if (rd_ap_i || wr_ap_i) begin
				// Write waits for the last word to land
				ap_pend_ff <= 1'b1;
				ap_cnt_ff <= wr_ap_i ? APW_CYC[TW-1:0] : APR_CYC[TW-1:0];
			end else if (ap_pend_ff) begin
				if (ap_cnt_ff == {TW{1'b0}}) begin
					ap_pend_ff <= 1'b0;
					open_ff <= 1'b0;
					pre_cnt_ff <= TRP_CYC[TW-1:0];
				end else begin
					ap_cnt_ff <= ap_cnt_ff - 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- logic/dbrc_top.v
/*
 * DDR4 bank and refresh command tracker: decodes command pins into
 * bank state, auto-precharge and refresh blackout with mode select.
 * Assumes pins from the controller arrive in another domain.
 */
// Operation
// - ACTIVATE opens row chosen by group, bank
// - PRECHARGE closes one or all banks
// - PRECHARGE on idle bank restarts timer
// - A10 high on READ/WRITE auto-precharges bank
// - Write auto-precharge waits for last word
// - REFRESH decode: cs, ras, cas low, we high
// - Internal refresh address; banks left idle
// - OTF samples BG0: 1x or set mode
`default_nettype none
`include "dbrc_map.vh"

module dbrc_top #(
	parameter ROW_W = `DBRC_ROW_W,
	parameter NB = `DBRC_BANKS
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Command and address pins from the controller
	input wire cs_n_i,
	input wire act_n_i,
	input wire ras_n_i,
	input wire cas_n_i,
	input wire we_n_i,
	input wire [1:0] bg_i,
	input wire [1:0] ba_i,
	input wire [ROW_W-1:0] addr_i,
	// Fine granularity refresh setting
	input wire otf_en_i,
	input wire [1:0] fgr_mode_i,
	// Bank and refresh status
	output wire [NB-1:0] bank_open_o,
	output wire [NB-1:0] bank_idle_o,
	output reg refresh_busy_o,
	output reg [1:0] ref_rate_o,
	output reg [31:0] ref_count_o
);

	// ****************************************
	// Cycle counts
	// ****************************************
	// Each figure in ns becomes whole clocks, rounded up so that a
	// timing is never shorter than the memory needs
	localparam integer TRP_C = (`DBRC_TRP_NS + `DBRC_CLK_NS - 1) /
		`DBRC_CLK_NS;
	localparam integer APR_C = (`DBRC_TRTP_NS + `DBRC_CLK_NS - 1) /
		`DBRC_CLK_NS;
	localparam integer APW_C = (`DBRC_TWR_NS + `DBRC_CLK_NS - 1) /
		`DBRC_CLK_NS;
	localparam integer RFC1_C = (`DBRC_TRFC1_NS + `DBRC_CLK_NS - 1) /
		`DBRC_CLK_NS;
	localparam integer RFC2_C = (`DBRC_TRFC2_NS + `DBRC_CLK_NS - 1) /
		`DBRC_CLK_NS;
	localparam integer RFC4_C = (`DBRC_TRFC4_NS + `DBRC_CLK_NS - 1) /
		`DBRC_CLK_NS;
	// Refresh state machine codes
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RFC = 2'h1;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Word layout, top down: command pins, bank bits, address, setting
	localparam CMD_W = `DBRC_CMD_W;
	localparam BANK_W = 4;
	localparam CFG_W = 3;
	localparam SW = CMD_W + BANK_W + ROW_W + CFG_W;
	// Reset word reads as a deselect with every control pin high, so
	// the first edges after reset never decode a phantom activate
	localparam [SW-1:0] SYNC_RST = {{CMD_W{1'b1}}, {(SW-CMD_W){1'b0}}};
	reg [SW-1:0] s1_ff;
	reg [SW-1:0] s2_ff;
	// Two stages on every pin; the first feeds only the second.
	// Pins are synchronised one by one: a command must stand a whole
	// clock and be followed by a deselect, or its bits may mix.
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= SYNC_RST;
			s2_ff <= SYNC_RST;
		end else begin
			s1_ff <= {cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, bg_i, ba_i,
				addr_i, otf_en_i, fgr_mode_i};
			s2_ff <= s1_ff;
		end
	end

	wire cs_n = s2_ff[SW-1];
	wire act_n = s2_ff[SW-2];
	wire [3:0] ctl = s2_ff[SW-2:SW-5];
	wire [1:0] bg = s2_ff[SW-6:SW-7];
	wire [1:0] ba = s2_ff[SW-8:SW-9];
	wire [ROW_W-1:0] addr = s2_ff[ROW_W+2:3];
	wire otf = s2_ff[2];
	wire [1:0] fgr = s2_ff[1:0];

	// ****************************************
	// Command decode
	// ****************************************
	// Commands come from the second stage only. Controller spacing
	// (activate gaps, window, precharge time) is not policed here: a
	// command that breaks it is still applied as it stands.
	reg [1:0] st_ff;
	wire live = !cs_n && (st_ff == ST_IDLE);
	wire [4:0] cmd = {cs_n, ctl};
	// Activate ignores the ras/cas/we meaning of those pins
	wire is_act = live && !act_n;
	wire is_ref = live && (cmd == `DBRC_CMD_REF);
	wire is_pre = live && (cmd == `DBRC_CMD_PRE);
	wire is_rd = live && (cmd == `DBRC_CMD_RD);
	wire is_wr = live && (cmd == `DBRC_CMD_WR);
	wire ap = addr[`DBRC_AP_BIT];
	wire [3:0] sel = {bg, ba};

	// ****************************************
	// Bank array
	// ****************************************
	// One tracker per bank; a refresh clears them all at once. The open
	// row is held per bank but nothing here compares against it yet.
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi = gi + 1) begin : g_bank
			localparam integer SLOT = gi;
			wire hit = (sel == SLOT[BANK_W-1:0]);
			dbrc_bank #(
				.ROW_W(ROW_W),
				.TW(8),
				.TRP_CYC(TRP_C[7:0]),
				.APR_CYC(APR_C[7:0]),
				.APW_CYC(APW_C[7:0])
			) u_bank (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.act_i(is_act && hit),
				.pre_i(is_pre && (hit || ap)),
				.rd_ap_i(is_rd && ap && hit),
				.wr_ap_i(is_wr && ap && hit),
				.ref_i(is_ref),
				.row_i(addr),
				.open_o(bank_open_o[gi]),
				.row_o(),
				.idle_o(bank_idle_o[gi])
			);
		end
	endgenerate

	// ****************************************
	// Refresh blackout and mode select
	// ****************************************
	// Blackout length is taken at the refresh edge and kept in the
	// counter, so a mode change during the blackout cannot stretch it
	reg [8:0] rfc_cnt_ff;
	reg [1:0] rate;
	reg [8:0] rfc_len;
	// OTF uses BG0: low picks 1x, high the programmed rate
	always @* begin
		rate = `DBRC_RM_1X;
		if (!otf)
			rate = fgr;
		else if (bg[0])
			rate = fgr;
		// Reserved mode codes fall back to the 1x blackout
		case (rate)
			`DBRC_RM_2X: rfc_len = RFC2_C[8:0];
			`DBRC_RM_4X: rfc_len = RFC4_C[8:0];
			default: rfc_len = RFC1_C[8:0];
		endcase
	end

	// Commands during tRFC are dropped; controller must send DES
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= ST_IDLE;
			rfc_cnt_ff <= 9'h000;
			refresh_busy_o <= 1'b0;
			ref_rate_o <= `DBRC_RM_1X;
			ref_count_o <= 32'h0000_0000;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (is_ref) begin
						st_ff <= ST_RFC;
						rfc_cnt_ff <= rfc_len - 9'h001;
						refresh_busy_o <= 1'b1;
						ref_rate_o <= rate;
						ref_count_o <= ref_count_o + 32'h0000_0001;
					end
				end
				ST_RFC: begin
					if (rfc_cnt_ff == 9'h000) begin
						st_ff <= ST_IDLE;
						refresh_busy_o <= 1'b0;
					end else begin
						rfc_cnt_ff <= rfc_cnt_ff - 9'h001;
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- sim/dbrc_top_properties.sv
/* Port checker for dbrc_top: bank and refresh state against commands.
   Assumes a command acts three edges after its pins are first sampled. */
`default_nettype none
`include "dbrc_map.vh"
module dbrc_top_properties #(parameter ROW_W = `DBRC_ROW_W, NB = 16) (
	// Clock, reset, command pins and refresh setting
	input wire clk_i, rst_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i,
	input wire [1:0] bg_i, ba_i,
	input wire [ROW_W-1:0] addr_i,
	input wire otf_en_i,
	input wire [1:0] fgr_mode_i,
	// Status
	input wire [NB-1:0] bank_open_o, bank_idle_o,
	input wire refresh_busy_o,
	input wire [1:0] ref_rate_o,
	input wire [31:0] ref_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [3:0] bk = {bg_i, ba_i};
	wire [4:0] c = {cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i};
	wire act = !cs_n_i && !act_n_i;
	wire ap = addr_i[`DBRC_AP_BIT];
	wire rf = c == `DBRC_CMD_REF;
	wire [7:0] trc = ref_rate_o == `DBRC_RM_1X ? 8'd35 :
		ref_rate_o == `DBRC_RM_2X ? 8'd26 : 8'd16;
	logic [7:0] busy_ff;
	// Length of the blackout so far, in cycles
	always @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 8'h00;
		end else begin
			busy_ff <= refresh_busy_o ? busy_ff + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_act_opens: assert property (act ##2 !refresh_busy_o |=>
		bank_open_o[$past(bk, 3)]) else $error("row not opened");
	a_pre_one: assert property (c == `DBRC_CMD_PRE && !ap ##2
		!refresh_busy_o |=> !bank_open_o[$past(bk, 3)] &&
		!bank_idle_o[$past(bk, 3)] ##2 bank_idle_o[$past(bk, 5)])
		else $error("precharge timing wrong");
	a_pre_all: assert property (c == `DBRC_CMD_PRE && ap ##2
		!refresh_busy_o |=> bank_open_o == '0) else $error("not all closed");
	a_ref_count: assert property (rf ##2 !refresh_busy_o |=>
		refresh_busy_o && bank_open_o == '0 &&
		ref_count_o == $past(ref_count_o) + 32'h1) else $error("ref start");
	a_ref_rate: assert property (rf ##2 !refresh_busy_o |=>
		ref_rate_o == ($past(otf_en_i && !bg_i[0], 3) ? `DBRC_RM_1X :
		$past(fgr_mode_i, 3))) else $error("refresh rate wrong");
	a_ref_done: assert property ($fell(refresh_busy_o) |->
		&bank_idle_o && busy_ff == trc) else $error("refresh length");
	a_rd_ap: assert property (c == `DBRC_CMD_RD && ap ##2
		!refresh_busy_o |=> bank_open_o[$past(bk, 3)] ##1
		bank_open_o[$past(bk, 4)] ##1 !bank_open_o[$past(bk, 5)])
		else $error("read auto-precharge");
	a_wr_ap: assert property (c == `DBRC_CMD_WR && ap ##2
		!refresh_busy_o |=> bank_open_o[$past(bk, 3)] ##1
		bank_open_o[$past(bk, 4)] ##1 bank_open_o[$past(bk, 5)] ##1
		!bank_open_o[$past(bk, 6)]) else $error("write auto-precharge");
endmodule
`default_nettype wire

//--- sim/dbrc_ctl_model.sv
/* Controller model: one command per call, then deselect.
   Assumes the caller picks gaps that keep the device's spacing. */
`default_nettype none
`include "dbrc_map.vh"
module dbrc_ctl_model (
	// Clock
	input wire logic clk_i,
	// Command pins {cs, act, ras, cas, we}, bank {bg, ba}, address
	output var logic [4:0] cmd_o,
	output var logic [3:0] bank_o,
	output var logic [17:0] addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_o = `DBRC_CMD_MASK;
		bank_o = 4'h0;
		addr_o = 18'h00000;
	end
	// Deselect flips bank and address so stale values never look held
	task automatic issue(input logic [4:0] c, input logic [3:0] b,
		input logic [17:0] a, input int gap);
		@(posedge clk_i);
		cmd_o <= c;
		bank_o <= b;
		addr_o <= a;
		@(posedge clk_i);
		cmd_o <= `DBRC_CMD_MASK;
		bank_o <= ~b;
		addr_o <= ~a;
		repeat (gap) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- sim/dbrc_top_tb.sv
/* Self-checking bench for dbrc_top, driven through dbrc_ctl_model.
   Assumes the tracker answers three edges after a command. */
`default_nettype none
`include "dbrc_map.vh"
module dbrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TRC[3] = '{`DBRC_TRFC1_NS / `DBRC_CLK_NS,
		`DBRC_TRFC2_NS / `DBRC_CLK_NS, `DBRC_TRFC4_NS / `DBRC_CLK_NS};
	logic clk_i, rst_i, otf_en_i;
	logic [1:0] fgr_mode_i;
	wire [4:0] cmd;
	wire [3:0] bank;
	wire [17:0] addr;
	wire [15:0] bank_open_o, bank_idle_o;
	wire refresh_busy_o;
	wire [1:0] ref_rate_o;
	wire [31:0] ref_count_o;
	int num_errors = 0, cmp_count = 0, nref = 0;
	dbrc_ctl_model ctl (.clk_i(clk_i), .cmd_o(cmd), .bank_o(bank),
		.addr_o(addr));
	dbrc_top dut (.clk_i, .rst_i, .cs_n_i(cmd[4]), .act_n_i(cmd[3]),
		.ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
		.bg_i(bank[3:2]), .ba_i(bank[1:0]), .addr_i(addr), .otf_en_i,
		.fgr_mode_i, .bank_open_o, .bank_idle_o, .refresh_busy_o,
		.ref_rate_o, .ref_count_o);
	task chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task st(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Open, close, then close an idle bank again to restart its timer
	task t_bank;
		ctl.issue(5'h00, 4'h5, 18'h00123, 0);
		st(2); chk(bank_open_o[5], 1);
		ctl.issue(`DBRC_CMD_PRE, 4'h5, 18'h00000, 0);
		st(2); chk({bank_open_o[5], bank_idle_o[5]}, 0);
		st(2); chk(bank_idle_o[5], 1);
		ctl.issue(`DBRC_CMD_PRE, 4'h5, 18'h00000, 0);
		st(2); chk(bank_idle_o[5], 0);
		st(2); chk(bank_idle_o[5], 1);
	endtask
	// Two groups open, one precharge closes both
	task t_all;
		ctl.issue(5'h00, 4'h0, 18'h00011, 2);
		ctl.issue(5'h00, 4'h9, 18'h00022, 0);
		st(2); chk(bank_open_o, 16'h0201);
		ctl.issue(`DBRC_CMD_PRE, 4'h0, 18'h00400, 0);
		st(2); chk(bank_open_o, 16'h0000);
	endtask
	// Auto-precharge on read, then a write to another bank while the
	// read's precharge is still pending; write stays open longer
	task t_ap;
		ctl.issue(5'h00, 4'h2, 18'h00033, 2);
		ctl.issue(5'h00, 4'h7, 18'h00044, 2);
		ctl.issue(`DBRC_CMD_RD, 4'h2, 18'h00400, 0);
		ctl.issue(`DBRC_CMD_WR, 4'h7, 18'h00400, 0);
		st(1); chk(bank_open_o[2], 1);
		st(1); chk(bank_open_o[2], 0);
		chk(bank_open_o[7], 1);
		st(2); chk(bank_open_o[7], 1);
		st(1); chk(bank_open_o[7], 0);
		st(4);
	endtask
	// Reset in mid-run: state clears, no phantom command follows it
	task t_rst;
		ctl.issue(5'h00, 4'h3, 18'h00066, 2);
		st(1); chk(bank_open_o[3], 1);
		@(posedge clk_i);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		st(1); chk(bank_open_o, 16'h0000);
		chk(ref_count_o, 0);
		st(1); chk(bank_open_o, 16'h0000);
		chk(bank_idle_o, 16'hffff);
	endtask
	// Refresh in one mode; an activate during the blackout is dropped
	task t_ref(input logic o, input logic [3:0] b, input logic [1:0] m, r);
		int n;
		@(posedge clk_i);
		otf_en_i <= o;
		fgr_mode_i <= m;
		ctl.issue(`DBRC_CMD_REF, b, 18'h3ffff, 0);
		ctl.issue(5'h00, 4'h1, 18'h00055, 0);
		nref++;
		st(1); chk(refresh_busy_o, 1);
		chk(ref_count_o, nref);
		chk(ref_rate_o, r);
		n = 0;
		while (refresh_busy_o === 1'b1 && n < 100) begin
			st(1);
			n++;
		end
		chk(n, TRC[r] - 1);
		chk({bank_open_o[1], &bank_idle_o}, 1);
	endtask
	task wrap_up;
		$display("errors %0d, compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	// Hang guard: the whole run is about 225 cycles, well under the 2000 allowed
	initial begin
		#20000;
		num_errors++;
		wrap_up;
	end
	initial begin
		rst_i = 1;
		otf_en_i = 0;
		fgr_mode_i = `DBRC_RM_1X;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		t_bank;
		t_all;
		t_ap;
		t_ref(0, 4'h0, `DBRC_RM_1X, `DBRC_RM_1X);
		t_ref(0, 4'h0, `DBRC_RM_2X, `DBRC_RM_2X);
		t_ref(0, 4'h0, `DBRC_RM_4X, `DBRC_RM_4X);
		t_ref(1, 4'h0, `DBRC_RM_4X, `DBRC_RM_1X);
		t_ref(1, 4'h4, `DBRC_RM_2X, `DBRC_RM_2X);
		t_rst;
		wrap_up;
	end
endmodule
bind dbrc_top dbrc_top_properties #(.ROW_W(ROW_W), .NB(NB)) chk (.clk_i,
	.rst_i, .cs_n_i, .act_n_i, .ras_n_i, .cas_n_i, .we_n_i, .bg_i, .ba_i,
	.addr_i, .otf_en_i, .fgr_mode_i, .bank_open_o, .bank_idle_o,
	.refresh_busy_o, .ref_rate_o, .ref_count_o);
`default_nettype wire
